// ---- uac_defines.svh ----
// constants for the serial command front end: opcodes, field positions, timing counts
// assumes a 100 MHz system clock; included by bare name wherever needed
`ifndef UAC_DEFINES_SVH
`define UAC_DEFINES_SVH

// bytes on the link
`define UAC_SYNC_BYTE            8'h55
`define UAC_FRAME_DATA_BITS      4'h8
`define UAC_FRAME_LAST_BIT       4'h9
`define UAC_SYNC_LAST_FALL       3'h3
`define UAC_SYNC_SPAN_SHIFT      3

// command bytes; stand-alone commands ignore bit 0
`define UAC_CMD_IGNORE_LOW_MASK  8'hFE
`define UAC_CMD_RESET            8'h06
`define UAC_CMD_START            8'h08
`define UAC_CMD_SLEEP            8'h02
`define UAC_CMD_READ_NIBBLE      4'h1
`define UAC_CMD_REG_READ_NIBBLE  4'h2
`define UAC_CMD_REG_WRITE_NIBBLE 4'h4
`define UAC_CMD_ADDR_MSB         3
`define UAC_CMD_ADDR_LSB         1
`define UAC_REG_ADDR_LAST        3'h4
`define UAC_REG_NO_RESTART       3'h4
`define UAC_REG_EMPTY_DATA       8'h00

// result words
`define UAC_RESULT_BYTES         2'h3
`define UAC_REG_BYTES            2'h1
`define UAC_RESULT_POS_FULL      24'h7FFFFF
`define UAC_RESULT_NEG_FULL      24'h800000

// timing
`define UAC_CLOCK_HZ             100000000
`define UAC_FMOD_NORMAL_HZ       256000
`define UAC_FMOD_TURBO_HZ        512000
`define UAC_TIMEOUT_MODS_NORMAL  32760
`define UAC_TIMEOUT_MODS_TURBO   65520
`define UAC_TIMEOUT_NORMAL_CYCLES (64'(`UAC_TIMEOUT_MODS_NORMAL) * `UAC_CLOCK_HZ / `UAC_FMOD_NORMAL_HZ)
`define UAC_TIMEOUT_TURBO_CYCLES  (64'(`UAC_TIMEOUT_MODS_TURBO) * `UAC_CLOCK_HZ / `UAC_FMOD_TURBO_HZ)
`define UAC_READY_HIGH_NS        1000
`define UAC_READY_HIGH_CYCLES    ((`UAC_READY_HIGH_NS * (`UAC_CLOCK_HZ / 1000000) + 999) / 1000)

`endif

// ---- uac_host.sv ----
// host side of the serial link: sends 8-N-1 bytes, collects answers
// rx idles high as with a pull-up; tx sampled mid bit
`timescale 1ns/100ps
`default_nettype none
module uac_host #(parameter int BIT = 16) (
	input  wire logic clock,
	input  wire logic tx,
	output var logic  rx
);
	logic [8:0] got_q[$];
	logic [8:0] sh;
	initial rx = 1'b1;
	// low start, lsb first, high stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			rx = f[i];
			repeat (BIT - 1) @(negedge clock);
		end
	endtask
	// stop bit kept in bit 8 for the bench
	initial forever begin
		@(negedge tx);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge clock);
			sh[i] = tx;
		end
		got_q.push_back(sh);
	end
endmodule
`default_nettype wire

// ---- uac_link_if.sv ----
// signals between the command controller and its receiver and transmitter
// all three ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface uac_link_if;
	logic [15:0] bit_period;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_busy;
	logic        sync_seen;
	logic        sync_expect;
	logic        rx_abort;
	logic        tx_start;
	logic [7:0]  tx_data;
	logic        tx_ready;

	modport receiver (output bit_period, rx_valid, rx_data, rx_busy, sync_seen, input sync_expect, rx_abort);
	modport transmitter (input bit_period, tx_start, tx_data, output tx_ready);
	modport control (input bit_period, rx_valid, rx_data, rx_busy, sync_seen, tx_ready,
		output sync_expect, rx_abort, tx_start, tx_data);
endinterface
`default_nettype wire

// ---- uac_pkg.sv ----
// state types of the serial command front end
// widths are fixed here; counts live in uac_defines.svh
package uac_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_MEASURE, RX_DATA, RX_STOP} uac_rx_phase_type;

	typedef struct packed {
		uac_rx_phase_type phase;
		logic [19:0]      measure;
		logic [15:0]      timer;
		logic [15:0]      period;
		logic [2:0]       falls;
		logic [3:0]       bits;
		logic [7:0]       shift;
		logic [7:0]       data;
		logic             is_sync;
		logic             valid;
		logic             sync_seen;
		logic             last_rx;
	} uac_rx_state_type;

	typedef struct packed {
		logic        active;
		logic [15:0] timer;
		logic [3:0]  bits;
		logic [8:0]  shift;
		logic        line;
	} uac_tx_state_type;

	typedef enum logic [2:0] {M_SYNC, M_CMD, M_WDATA, M_RREAD, M_SEND} uac_phase_type;

	typedef struct packed {
		uac_phase_type phase;
		logic [2:0]    reg_addr;
		logic [7:0]    reg_wdata;
		logic          reg_write;
		logic [23:0]   send_word;
		logic [1:0]    send_left;
		logic [31:0]   idle_timer;
		logic          rx_abort;
		logic [23:0]   latest;
		logic [23:0]   snapshot;
		logic          newer_pending;
		logic          ready_n;
		logic [15:0]   hold;
		logic          fall_pending;
		logic          powered_down;
		logic          conv_run;
		logic          conv_cont;
		logic          conv_restart;
		logic          sleep_pending;
		logic          device_reset;
	} uac_state_type;

endpackage

// ---- uac_rx.sv ----
// receiver: measures the bit period on the sync byte, then samples 8-N-1 bytes
// rx is taken as synchronous to clock
`timescale 1ns/100ps
`default_nettype none
`include "uac_defines.svh"
module uac_rx (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// serial line, input only
	input  wire logic       rx,
	// controller side
	uac_link_if.receiver    link
);
	uac_pkg::uac_rx_state_type st;
	uac_pkg::uac_rx_state_type next_st;
	logic                      fall;
	logic [15:0]               span;

	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		next_st.sync_seen = 1'b0;
		next_st.last_rx = rx;
		fall = st.last_rx & ~rx;
		span = st.measure[18:3];
		case (st.phase)
			uac_pkg::RX_IDLE: begin
				if (fall && link.sync_expect) begin
					next_st.phase = uac_pkg::RX_MEASURE;
					next_st.measure = 20'h00001;
					next_st.falls = 3'h0;
				end else if (fall) begin
					next_st.phase = uac_pkg::RX_DATA;
					next_st.timer = st.period >> 1;
					next_st.bits = 4'h0;
					next_st.is_sync = 1'b0;
				end
			end
			uac_pkg::RX_MEASURE: begin
				next_st.measure = st.measure + 20'h00001;
				if (fall) begin
					next_st.falls = st.falls + 3'h1;
				end
				if (fall && st.falls == `UAC_SYNC_LAST_FALL) begin
					next_st.period = span;
					next_st.timer = span + (span >> 1);
					next_st.is_sync = 1'b1;
					next_st.phase = uac_pkg::RX_STOP;
				end
			end
			uac_pkg::RX_DATA: begin
				next_st.timer = st.timer - 16'h0001;
				if (st.timer == 16'h0000) begin
					next_st.timer = st.period - 16'h0001;
					next_st.bits = st.bits + 4'h1;
					if (st.bits == 4'h0 && rx) begin
						next_st.phase = uac_pkg::RX_IDLE;
					end else if (st.bits != 4'h0) begin
						next_st.shift = {rx, st.shift[7:1]};
					end
					if (st.bits == `UAC_FRAME_DATA_BITS) begin
						next_st.phase = uac_pkg::RX_STOP;
					end
				end
			end
			uac_pkg::RX_STOP: begin
				next_st.timer = st.timer - 16'h0001;
				if (st.timer == 16'h0000) begin
					next_st.phase = uac_pkg::RX_IDLE;
					next_st.data = st.shift;
					next_st.valid = rx & ~st.is_sync;
					next_st.sync_seen = rx & st.is_sync;
				end
			end
			default: next_st.phase = uac_pkg::RX_IDLE;
		endcase
		if (link.rx_abort) begin
			next_st.phase = uac_pkg::RX_IDLE;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.last_rx <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign link.bit_period = st.period;
	assign link.rx_valid = st.valid;
	assign link.rx_data = st.data;
	assign link.sync_seen = st.sync_seen;
	assign link.rx_busy = st.phase != uac_pkg::RX_IDLE;
endmodule
`default_nettype wire

// ---- uac_top.sv ----
// serial command front end of a delta-sigma converter: sync, decode, power, ready flag
// the converter core and the configuration store sit outside and follow the strobes here
`timescale 1ns/100ps
`default_nettype none
`include "uac_defines.svh"
// What this block does
// - sleep waits for running conversion, then powers down
// - powered down keeps settings, takes commands
// - start wakes, single or continuous per mode
// - never start a byte while host transmits
// - rx input only, tx idles high
// - ready on pin only if output, selected
// - ready low on result, high when loaded
// - unread continuous result: ready pulses high first
// - frames: start, eight bits lsb first, stop
// - sync byte before each command sets baud
// - idle mid-command too long resets interface
// - results are 24-bit two's complement
// - results clip at both full-scale codes
// - reset, start, sleep decoded ignoring bit zero
// - upper nibble one means read result
// - register commands carry address bits 3:1
// - words go least significant byte first
// - single-shot start mid-conversion restarts one
// - continuous start again restarts conversions
// - read loads newest result right after command
// - result during read byte keeps ready low
// - read of missing register returns zero
// - commands act only at mid stop bit
// - write except address four restarts conversion
module uac_top #(
	parameter int          RAW_WIDTH             = 26,
	parameter logic [31:0] TIMEOUT_NORMAL_CYCLES = 32'(`UAC_TIMEOUT_NORMAL_CYCLES),
	parameter logic [31:0] TIMEOUT_TURBO_CYCLES  = 32'(`UAC_TIMEOUT_TURBO_CYCLES),
	parameter logic [15:0] READY_HIGH_CYCLES     = 16'(`UAC_READY_HIGH_CYCLES)
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	// serial link
	input  wire logic                        rx,
	output logic                             tx,
	// configuration levels from the register store
	input  wire logic                        conversion_mode_bit,
	input  wire logic                        turbo_mode,
	input  wire logic                        pin2_direction,
	input  wire logic                        pin2_function_select,
	input  wire logic                        pin2_gpio_value,
	// register store access
	output logic [2:0]                       reg_addr,
	output logic [7:0]                       reg_wdata,
	output logic                             reg_write,
	input  wire logic [7:0]                  reg_rdata,
	output logic                             device_reset,
	// converter core
	output logic                             conv_run,
	output logic                             conv_continuous,
	output logic                             conv_restart,
	input  wire logic                        conv_done,
	input  wire logic                        conv_near_done,
	input  wire logic signed [RAW_WIDTH-1:0] conv_raw,
	// power
	output logic                             analog_power_on,
	output logic                             excitation_current_sources,
	// shared pin 2
	output logic                             result_ready_n,
	output logic                             pin2_out,
	output logic                             pin2_oe_n
);
	uac_link_if link ();

	uac_pkg::uac_state_type st;
	uac_pkg::uac_state_type next_st;
	logic [23:0]            clipped;
	logic [31:0]            timeout_limit;
	logic                   counting;
	logic                   tx_go;
	logic [7:0]             cmd;

	uac_rx u_rx (
		.clock (clock),
		.rst_b (rst_b),
		.rx    (rx),
		.link  (link.receiver)
	);

	uac_tx u_tx (
		.clock (clock),
		.rst_b (rst_b),
		.tx    (tx),
		.link  (link.transmitter)
	);

	function automatic logic [23:0] clip_result(input logic signed [RAW_WIDTH-1:0] raw);
		logic signed [RAW_WIDTH-1:0] top;
		logic signed [RAW_WIDTH-1:0] bottom;
		top = RAW_WIDTH'($signed(`UAC_RESULT_POS_FULL));
		bottom = -top - RAW_WIDTH'(1);
		if (raw > top) begin
			return `UAC_RESULT_POS_FULL;
		end else if (raw < bottom) begin
			return `UAC_RESULT_NEG_FULL;
		end
		return raw[23:0];
	endfunction

	always_comb begin
		next_st = st;
		next_st.reg_write = 1'b0;
		next_st.rx_abort = 1'b0;
		next_st.conv_restart = 1'b0;
		next_st.device_reset = 1'b0;
		cmd = link.rx_data;
		clipped = clip_result(conv_raw);
		timeout_limit = turbo_mode ? TIMEOUT_TURBO_CYCLES : TIMEOUT_NORMAL_CYCLES;
		// hold off while the host is sending
		tx_go = (st.phase == uac_pkg::M_SEND) && link.tx_ready && !link.rx_busy && (st.send_left != 2'h0);

		// result tracking; snapshot is what the host sees if a byte is in flight
		if (conv_done) begin
			next_st.latest = clipped;
		end
		// note a result that lands mid-byte
		if (conv_done && link.rx_busy) begin
			next_st.newer_pending = 1'b1;
		end else if (!link.rx_busy) begin
			next_st.newer_pending = 1'b0;
			next_st.snapshot = conv_done ? clipped : st.latest;
		end

		// ready falls on a new result
		if (st.hold != 16'h0000) begin
			next_st.hold = st.hold - 16'h0001;
			if (st.hold == 16'h0001 && st.fall_pending) begin
				next_st.ready_n = 1'b0;
				next_st.fall_pending = 1'b0;
			end
		end
		if (conv_done && st.hold > 16'h0001) begin
			next_st.fall_pending = 1'b1;
		end else if (conv_done) begin
			next_st.ready_n = 1'b0;
			next_st.fall_pending = 1'b0;
		end
		// unread result: high pulse before next
		if (conv_near_done && st.conv_cont && st.conv_run && !st.ready_n) begin
			next_st.ready_n = 1'b1;
			next_st.hold = READY_HIGH_CYCLES;
		end

		// finish the running conversion, then sleep
		if (conv_done && (!st.conv_cont || st.sleep_pending)) begin
			next_st.conv_run = 1'b0;
		end
		if (conv_done && st.sleep_pending) begin
			next_st.powered_down = 1'b1;
			next_st.sleep_pending = 1'b0;
		end

		counting = (st.phase == uac_pkg::M_CMD) || (st.phase == uac_pkg::M_WDATA) ||
			((st.phase == uac_pkg::M_SYNC) && link.rx_busy);
		if (!counting || link.rx_valid || link.sync_seen) begin
			next_st.idle_timer = 32'h00000000;
		end else if (st.idle_timer >= timeout_limit - 32'h00000001) begin
			next_st.idle_timer = 32'h00000000;
			next_st.phase = uac_pkg::M_SYNC;
			next_st.rx_abort = 1'b1;
		end else begin
			next_st.idle_timer = st.idle_timer + 32'h00000001;
		end

		case (st.phase)
			uac_pkg::M_SYNC: begin
				// every command follows a fresh sync
				if (link.sync_seen) begin
					next_st.phase = uac_pkg::M_CMD;
				end
			end
			uac_pkg::M_CMD: begin
				// act only on a latched byte
				if (link.rx_valid) begin
					next_st.phase = uac_pkg::M_SYNC;
					if ((cmd & `UAC_CMD_IGNORE_LOW_MASK) == `UAC_CMD_RESET) begin
						next_st.device_reset = 1'b1;
						next_st.powered_down = 1'b1;
						next_st.conv_run = 1'b0;
						next_st.conv_cont = 1'b0;
						next_st.sleep_pending = 1'b0;
						next_st.ready_n = 1'b1;
						next_st.hold = 16'h0000;
						next_st.fall_pending = 1'b0;
					end else if ((cmd & `UAC_CMD_IGNORE_LOW_MASK) == `UAC_CMD_START) begin
						next_st.powered_down = 1'b0;
						next_st.sleep_pending = 1'b0;
						next_st.conv_run = 1'b1;
						next_st.conv_cont = conversion_mode_bit;
						next_st.conv_restart = 1'b1;
					end else if ((cmd & `UAC_CMD_IGNORE_LOW_MASK) == `UAC_CMD_SLEEP) begin
						if (st.conv_run) begin
							next_st.sleep_pending = 1'b1;
						end else begin
							next_st.powered_down = 1'b1;
						end
					end else if (cmd[7:4] == `UAC_CMD_READ_NIBBLE) begin
						next_st.phase = uac_pkg::M_SEND;
						next_st.send_left = `UAC_RESULT_BYTES;
						if (st.newer_pending || (conv_done && link.rx_busy)) begin
							next_st.send_word = st.snapshot;
						end else begin
							next_st.send_word = conv_done ? clipped : st.latest;
							next_st.ready_n = 1'b1;
							next_st.hold = 16'h0000;
							next_st.fall_pending = 1'b0;
						end
					end else if (cmd[7:4] == `UAC_CMD_REG_READ_NIBBLE) begin
						next_st.reg_addr = cmd[`UAC_CMD_ADDR_MSB:`UAC_CMD_ADDR_LSB];
						next_st.phase = uac_pkg::M_RREAD;
					end else if (cmd[7:4] == `UAC_CMD_REG_WRITE_NIBBLE) begin
						next_st.reg_addr = cmd[`UAC_CMD_ADDR_MSB:`UAC_CMD_ADDR_LSB];
						next_st.phase = uac_pkg::M_WDATA;
					end
				end
			end
			uac_pkg::M_WDATA: begin
				if (link.rx_valid) begin
					next_st.phase = uac_pkg::M_SYNC;
					// writes beyond the last address are dropped
					if (st.reg_addr <= `UAC_REG_ADDR_LAST) begin
						next_st.reg_wdata = cmd;
						next_st.reg_write = 1'b1;
						if (st.reg_addr != `UAC_REG_NO_RESTART && st.conv_run) begin
							next_st.conv_restart = 1'b1;
						end
					end
				end
			end
			uac_pkg::M_RREAD: begin
				next_st.send_word = {16'h0000,
					(st.reg_addr <= `UAC_REG_ADDR_LAST) ? reg_rdata : `UAC_REG_EMPTY_DATA};
				next_st.send_left = `UAC_REG_BYTES;
				next_st.phase = uac_pkg::M_SEND;
			end
			uac_pkg::M_SEND: begin
				if (tx_go) begin
					next_st.send_word = {8'h00, st.send_word[23:8]};
					next_st.send_left = st.send_left - 2'h1;
				end
				if (st.send_left == 2'h0 && link.tx_ready) begin
					next_st.phase = uac_pkg::M_SYNC;
				end
			end
			default: next_st.phase = uac_pkg::M_SYNC;
		endcase

		if (next_st.powered_down) begin
			next_st.conv_run = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.phase <= uac_pkg::M_SYNC;
			st.ready_n <= 1'b1;
			st.powered_down <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign link.sync_expect = st.phase == uac_pkg::M_SYNC;
	assign link.rx_abort = st.rx_abort;
	assign link.tx_start = tx_go;
	assign link.tx_data = st.send_word[7:0];

	assign reg_addr = st.reg_addr;
	assign reg_wdata = st.reg_wdata;
	assign reg_write = st.reg_write;
	assign device_reset = st.device_reset;
	assign conv_run = st.conv_run;
	assign conv_continuous = st.conv_cont;
	assign conv_restart = st.conv_restart;
	// analog and both current sources off
	assign analog_power_on = ~st.powered_down;
	assign excitation_current_sources = ~st.powered_down;
	assign result_ready_n = st.ready_n;
	// ready reaches pin only when selected
	assign pin2_oe_n = ~pin2_direction;
	assign pin2_out = pin2_function_select ? st.ready_n : pin2_gpio_value;
endmodule
`default_nettype wire

// ---- uac_top_bench.sv ----
// self-checking bench for the command front end
// host model on the pins; core and store modelled here
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t value mismatch", $time); end end
module uac_top_bench;
	logic clock, rst_b, tx, rx, mode, sel, dir, gpio, wr, rcmd, run, cont, rs, done;
	logic pwr, ex, rdy_n, p2o, p2oe_n, sw, srs, srst, turbo, near;
	logic [23:0] old;
	logic [2:0] ra, swa;
	logic [7:0] wd, swd, b0, b1, b2, d;
	logic signed [25:0] raw;
	int err_count, samples_checked, seed;
	uac_top #(.TIMEOUT_NORMAL_CYCLES(32'h7D0), .TIMEOUT_TURBO_CYCLES(32'h7D0), .READY_HIGH_CYCLES(16'h4)) dut (
		.clock, .rst_b, .rx, .tx, .conversion_mode_bit(mode), .turbo_mode(turbo), .pin2_direction(dir),
		.pin2_function_select(sel), .pin2_gpio_value(gpio), .reg_addr(ra), .reg_wdata(wd), .reg_write(wr),
		.reg_rdata({5'h15, ra}), .device_reset(rcmd), .conv_run(run), .conv_continuous(cont),
		.conv_restart(rs), .conv_done(done), .conv_near_done(near), .conv_raw(raw), .analog_power_on(pwr),
		.excitation_current_sources(ex), .result_ready_n(rdy_n), .pin2_out(p2o), .pin2_oe_n(p2oe_n));
	uac_host host (.clock, .tx, .rx);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (wr) begin
			sw <= 1'b1;
			swa <= ra;
			swd <= wd;
		end
		if (rs)
			srs <= 1'b1;
		if (rcmd)
			srst <= 1'b1;
	end
	function automatic logic [23:0] clip(input logic signed [25:0] r);
		if (r > 26'sh7FFFFF)
			return 24'h7FFFFF;
		if (r < -26'sh800000)
			return 24'h800000;
		return r[23:0];
	endfunction
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// gap first: host waits out the device's last stop bit
	task automatic cmd(input logic [7:0] c);
		repeat (16) @(negedge clock);
		host.send(8'h55);
		host.send(c);
		repeat (4) @(negedge clock);
	endtask
	task automatic get(output logic [7:0] v);
		logic [8:0] t;
		int n;
		n = 0;
		while (host.got_q.size() == 0 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			v = 8'h00;
		end else begin
			t = host.got_q.pop_front();
			`CHK(t[8], 1'b1)
			v = t[7:0];
		end
	endtask
	task automatic pulse_done();
		done = 1'b1;
		@(negedge clock);
		done = 1'b0;
		@(negedge clock);
	endtask
	initial begin
		repeat (90000) @(posedge clock);
		err_count++;
		print_verdict();
	end
	initial begin
		seed = 32'h9D1FE7D2;
		{rst_b, mode, sel, dir, gpio, done, raw, sw, srs, srst, near} = '0;
		mode = 1'b1;
		turbo = 1'($random(seed));
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		`CHK({tx, rdy_n, pwr}, 3'b110)
		cmd(8'h08 | 8'($random(seed) & 1));
		`CHK({srs, pwr, run, cont}, 4'hF)
		for (int k = 0; k < 6; k++) begin
			raw = k == 0 ? 26'h1000000 : k == 1 ? 26'h3000000 : k == 2 ? 26'h07FFFFF : k == 3 ? 26'h3800000 : 26'($random(seed));
			{sel, dir, gpio} = 3'($random(seed));
			pulse_done();
			repeat (8) @(negedge clock);
			`CHK(rdy_n, 1'b0)
			cmd(8'h10 | 8'($random(seed) & 15));
			get(b0);
			get(b1);
			get(b2);
			`CHK({b2, b1, b0}, clip(raw))
			`CHK(rdy_n, 1'b1)
		end
		// unread result: flag pulses high, falls again on the next one
		pulse_done();
		near = 1'b1;
		@(negedge clock);
		near = 1'b0;
		@(negedge clock);
		`CHK(rdy_n, 1'b1)
		old = clip(raw);
		pulse_done();
		repeat (8) @(negedge clock);
		`CHK(rdy_n, 1'b0)
		// result lands mid command byte: older word goes out, flag stays low
		raw = 26'($random(seed));
		fork
			cmd(8'h10);
			begin
				repeat (256) @(negedge clock);
				pulse_done();
			end
		join
		get(b0);
		get(b1);
		get(b2);
		`CHK({b2, b1, b0}, old)
		`CHK(rdy_n, 1'b0)
		cmd(8'h1F);
		get(b0);
		get(b1);
		get(b2);
		`CHK({b2, b1, b0}, clip(raw))
		`CHK(rdy_n, 1'b1)
		for (int k = 0; k < 8; k++) begin
			{sw, srs} = 2'b00;
			d = 8'($random(seed));
			cmd(8'h40 | 8'(k << 1));
			host.send(d);
			repeat (4) @(negedge clock);
			`CHK({sw, srs}, {k < 5, k < 5 && k != 4})
			if (k < 5)
				`CHK({swa, swd}, {3'(k), d})
		end
		cmd(8'h02 | 8'($random(seed) & 1));
		`CHK(pwr, 1'b1)
		pulse_done();
		`CHK({pwr, ex, run}, 3'b000)
		for (int k = 0; k < 8; k++) begin
			cmd(8'h20 | 8'(k << 1));
			get(b0);
			`CHK(b0, k < 5 ? {5'h15, 3'(k)} : 8'h00)
		end
		{mode, srs} = 2'b00;
		cmd(8'h08);
		`CHK({srs, pwr, run, cont}, 4'hE)
		srs = 1'b0;
		cmd(8'h09);
		`CHK({srs, run}, 2'b11)
		pulse_done();
		`CHK(run, 1'b0)
		// abandoned after sync; retry from scratch
		host.send(8'h55);
		repeat (2500) @(negedge clock);
		cmd(8'h20);
		get(b0);
		`CHK(b0, 8'hA8)
		cmd(8'h06 | 8'($random(seed) & 1));
		`CHK(srst, 1'b1)
		repeat (200) @(negedge clock);
		cmd(8'h22);
		get(b0);
		`CHK(b0, 8'hA9)
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- uac_top_monitor.sv ----
// concurrent checks on the top ports of the command front end
// bound onto every uac_top; single clock domain
`timescale 1ns/100ps
`default_nettype none
module uac_top_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst_b,
	// serial link
	input wire logic       rx,
	input wire logic       tx,
	// core and store
	input wire logic       conv_run,
	input wire logic       conv_restart,
	input wire logic       conv_done,
	input wire logic       reg_write,
	input wire logic [2:0] reg_addr,
	// power and pin 2
	input wire logic       analog_power_on,
	input wire logic       excitation_current_sources,
	input wire logic       result_ready_n,
	input wire logic       pin2_out,
	input wire logic       pin2_oe_n,
	input wire logic       pin2_direction,
	input wire logic       pin2_function_select,
	input wire logic       pin2_gpio_value
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_pin_ready_mux: assert property (pin2_out == (pin2_function_select ? result_ready_n : pin2_gpio_value))
		else $error("pin2 mux wrong");
	a_pin_drive_dir: assert property (pin2_oe_n == !pin2_direction)
		else $error("pin2 enable wrong");
	a_power_pair: assert property (analog_power_on == excitation_current_sources)
		else $error("power outputs differ");
	a_sleep_after_conv: assert property ($fell(analog_power_on) |-> !conv_run)
		else $error("powered down mid conversion");
	a_tx_rx_quiet: assert property ($fell(tx) |-> rx)
		else $error("tx began while host sends");
	a_start_bit_low: assert property ($fell(tx) |-> !tx [*8])
		else $error("start bit too short");
	a_write_addr_valid: assert property (reg_write |-> reg_addr <= 3'h4)
		else $error("write to missing register");
	a_write_restart: assert property (reg_write && reg_addr != 3'h4 && conv_run |-> conv_restart)
		else $error("write did not restart");
	a_ready_on_result: assert property (conv_done |-> ##[1:8] !result_ready_n)
		else $error("ready did not fall");
endmodule
bind uac_top uac_top_monitor mon (.clock, .rst_b, .rx, .tx, .conv_run, .conv_restart, .conv_done, .reg_write,
	.reg_addr, .analog_power_on, .excitation_current_sources, .result_ready_n, .pin2_out, .pin2_oe_n,
	.pin2_direction, .pin2_function_select, .pin2_gpio_value);
`default_nettype wire

// ---- uac_tx.sv ----
// transmitter: 8-N-1 frames at the measured bit period
// the line idles high; a start is taken only while tx_ready is high
`timescale 1ns/100ps
`default_nettype none
`include "uac_defines.svh"
module uac_tx (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// serial line
	output logic            tx,
	// controller side
	uac_link_if.transmitter link
);
	uac_pkg::uac_tx_state_type st;
	uac_pkg::uac_tx_state_type next_st;

	always_comb begin
		next_st = st;
		if (!st.active) begin
			next_st.line = 1'b1;
			if (link.tx_start) begin
				next_st.active = 1'b1;
				next_st.shift = {1'b1, link.tx_data};
				next_st.bits = 4'h0;
				next_st.timer = link.bit_period - 16'h0001;
				next_st.line = 1'b0;
			end
		end else begin
			next_st.timer = st.timer - 16'h0001;
			if (st.timer == 16'h0000) begin
				next_st.timer = link.bit_period - 16'h0001;
				next_st.bits = st.bits + 4'h1;
				next_st.line = st.shift[0];
				next_st.shift = {1'b1, st.shift[8:1]};
				if (st.bits == `UAC_FRAME_LAST_BIT) begin
					next_st.active = 1'b0;
					next_st.line = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.line <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign tx = st.line;
	assign link.tx_ready = ~st.active;
endmodule
`default_nettype wire
